// file: logic/spf_framer.sv
// scan data packet framer with apb registers and 8n1 transmitter
// assumes field and error pins are asynchronous and pclk is 10 MHz
`timescale 1ns/1ps
`default_nettype none
module spf_framer
#(
    parameter int BAUD = spf_pkg::BAUD_DEF
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        person_field_switch_state,
    input  wire logic        object_field_switch_state,
    input  wire logic        dev_error,
    input  wire logic        window_warn,
    input  wire logic        func_active,
    input  wire logic        dialog_req,
    output logic             txd,
    output logic             frame_busy
);
    import spf_pkg::*;

    localparam int DIV = CLK_HZ / BAUD; // bit period in clocks

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00, // waiting for start
        ST_SEND = 2'b01, // feeding bytes
        ST_WAIT = 2'b10  // last byte still shifting
    } spf_state_t;

    // ==========================================================
    // pin synchronisers
    logic [5:0] pin_meta_q; // first stage, read only by second
    logic [5:0] pin_q;      // usable pin levels
    // both stages reset to zero, levels arrive two clocks later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_q <= 6'h00;
            pin_q      <= 6'h00;
        end
        else
        begin
            pin_meta_q <= {dialog_req, func_active, window_warn,
                           dev_error, object_field_switch_state,
                           person_field_switch_state};
            pin_q      <= pin_meta_q;
        end
    end

    // ==========================================================
    // apb slave, one wait state so outputs come from flops
    logic        acc_en;   // access phase
    logic        wr_ok;    // write commits this edge
    logic [4:0]  type_q;   // type code for next packet
    logic [1:0]  seg_q;    // segment index
    logic [7:0]  wptr_q;   // payload write pointer, also count
    logic [13:0] err_q;    // error code word
    logic        errmode_q;
    logic        dlg_q;    // sticky dialog request
    logic        start_d;  // start pulse
    logic [7:0]  status_b; // live status byte
    logic [6:0]  mem [0:255]; // payload bytes, top bit added on send
    spf_state_t  st_q;

    assign acc_en  = psel && penable;
    assign wr_ok   = acc_en && pready && pwrite;
    assign start_d = wr_ok && paddr == OFS_CMD && pwdata[CMD_START];

    // pready pulses on the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc_en && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (acc_en && !pready)
            begin
                case (paddr)
                    OFS_CTRL:  prdata <= {22'h0, seg_q, 3'h0, type_q};
                    OFS_CMD:   prdata <= {29'h0, errmode_q, 2'h0};
                    OFS_PTR:   prdata <= {24'h0, wptr_q};
                    OFS_PDATA: prdata <= 32'h0000_0000;
                    OFS_PDIST: prdata <= 32'h0000_0000;
                    OFS_ERR:   prdata <= {18'h0, err_q};
                    OFS_STAT:  prdata <= {23'h0, st_q != ST_IDLE,
                                          status_b};
                    default:   pslverr <= 1'b1; // unmapped
                endcase
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_q    <= TYPE_RST;
            seg_q     <= 2'h0;
            err_q     <= 14'h0000;
            errmode_q <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (paddr == OFS_CTRL)
            begin
                type_q <= pwdata[4:0];
                seg_q  <= pwdata[CTRL_SEG_LO +: 2];
            end
            if (paddr == OFS_ERR)
                err_q <= pwdata[13:0];
            if (paddr == OFS_CMD)
                errmode_q <= pwdata[CMD_ERRMODE];
        end
    end

    // payload pointer; distance writes take two slots
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wptr_q <= 8'h00;
        else if (wr_ok && paddr == OFS_PTR)
            wptr_q <= pwdata[7:0];
        else if (wr_ok && paddr == OFS_PDATA)
            wptr_q <= wptr_q + 8'h01;
        else if (wr_ok && paddr == OFS_PDIST)
            wptr_q <= wptr_q + 8'h02;
    end

    // payload store, sectors in the order software writes them
    always_ff @(posedge pclk)
    begin
        if (wr_ok && paddr == OFS_PDATA)
            mem[wptr_q] <= pwdata[6:0]; // [R10]
        if (wr_ok && paddr == OFS_PDIST)
        begin
            // word in 4 mm steps, high seven bits first [R13] [R15]
            mem[wptr_q]         <= pwdata[13:7];
            mem[wptr_q + 8'h01] <= pwdata[6:0];
        end
    end

    // sticky dialog flag; a new request beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dlg_q <= 1'b0;
        else if (pin_q[5])
            dlg_q <= 1'b1; // [R22]
        else if (wr_ok && paddr == OFS_CMD && pwdata[CMD_CLRDLG])
            dlg_q <= 1'b0;
    end

    // status byte built from live pin levels in bits 0 to 4, bit 6 is the sticky dialog flag, bits 5 and 7 are fixed
    always_comb
    begin
        status_b            = 8'h80;       // bit 7 constant [R22]
        status_b[SB_PERSON] = pin_q[0];    // [R18]
        status_b[SB_OBJECT] = pin_q[1];    // [R19]
        status_b[SB_ERROR]  = pin_q[2];    // [R20]
        status_b[SB_WARN]   = pin_q[3];    // [R20]
        status_b[SB_ACTIVE] = pin_q[4];    // bit 5 stays zero [R21]
        status_b[SB_DIALOG] = dlg_q;
    end

    // ==========================================================
    // packet sequencer
    logic [8:0] pos_q;   // byte position in packet
    logic [8:0] n_q;     // payload bytes of this packet
    logic [4:0] ptype_q; // type latched at start
    logic [1:0] pseg_q;  // segment latched at start
    logic       perr_q;  // error packet
    logic [6:0] csum_q;  // running checksum
    logic       ld;      // hand byte to transmitter
    logic [7:0] byte_d;  // byte at current position
    logic       u_busy_q;
    logic [7:0] pidx;    // payload index

    assign ld   = st_q == ST_SEND && !u_busy_q;
    assign pidx = 8'(pos_q - 9'd3);

    // byte chooser; all information bytes carry bit 7 [R4]
    always_comb
    begin
        byte_d = ETX_BYTE; // [R2]
        if (pos_q == 9'd0)
            byte_d = STX_BYTE; // [R1]
        else if (pos_q == 9'd1)
            byte_d = INFO_BASE | {3'h0, ptype_q}; // [R6] [R11] [R17]
        else if (pos_q == 9'd2)
            byte_d = INFO_BASE | {1'b0, n_q[7:1]}; // [R7]
        else if (pos_q < n_q + 9'd3)
        begin
            if (perr_q) // error code in place of distances [R24]
                byte_d = {1'b1, pidx[0] ? err_q[6:0] : err_q[13:7]};
            else
                byte_d = {1'b1, mem[pidx]}; // [R8] [R12] [R16]
        end
        else if (pos_q == n_q + 9'd3)
            byte_d = status_b; // [R9]
        else if (pos_q == n_q + 9'd4)
            byte_d = INFO_BASE | {6'h00, pseg_q}; // [R26]
        else if (pos_q == n_q + 9'd5)
            byte_d = {1'b1, csum_q}; // [R25]
    end

    // state, position and latched header
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q    <= ST_IDLE;
            pos_q   <= 9'd0;
            n_q     <= 9'd0;
            ptype_q <= TYPE_RST;
            pseg_q  <= 2'h0;
            perr_q  <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                    if (start_d) // start while busy is ignored
                    begin
                        st_q   <= ST_SEND;
                        pos_q  <= 9'd0;
                        pseg_q <= seg_q;
                        perr_q <= errmode_q && pin_q[2];
                        if (errmode_q && pin_q[2])
                        begin
                            ptype_q <= TYPE_ERR; // [R24]
                            n_q     <= 9'd2;
                        end
                        else
                        begin
                            ptype_q <= type_q;
                            n_q     <= {1'b0, wptr_q};
                        end
                    end
                ST_SEND:
                    if (ld)
                    begin
                        pos_q <= pos_q + 9'd1;
                        if (pos_q == n_q + 9'd6)
                            st_q <= ST_WAIT;
                    end
                ST_WAIT:
                    if (!u_busy_q)
                        st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // checksum over type through segment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            csum_q <= 7'h00;
        else if (st_q == ST_IDLE)
            csum_q <= 7'h00;
        else if (ld && pos_q != 9'd0 && pos_q < n_q + 9'd5)
            csum_q <= csum_step(csum_q, byte_d); // [R25]
    end

    // busy flag runs independently of the pin logic [R23]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_busy <= 1'b0;
        else
            frame_busy <= (st_q != ST_IDLE) || start_d;
    end

    // ==========================================================
    // 8n1 transmitter
    logic [9:0]  sh_q;   // stop, data lsb first, start
    logic [3:0]  bit_q;  // bits left
    logic [15:0] div_q;  // baud counter

    // shifts one bit per baud period [R5]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q     <= 10'h3FF;
            bit_q    <= 4'h0;
            div_q    <= 16'h0000;
            u_busy_q <= 1'b0;
            txd      <= 1'b1;
        end
        else if (ld)
        begin
            sh_q     <= {1'b1, byte_d, 1'b0}; // [R5]
            bit_q    <= 4'd10;
            div_q    <= 16'(DIV - 1);
            u_busy_q <= 1'b1;
            txd      <= 1'b0; // start bit
        end
        else if (u_busy_q)
        begin
            if (div_q != 16'h0000)
                div_q <= div_q - 16'h0001;
            else if (bit_q == 4'd1)
            begin
                u_busy_q <= 1'b0; // stop bit done
                txd      <= 1'b1;
                bit_q    <= 4'h0;
            end
            else
            begin
                sh_q  <= {1'b1, sh_q[9:1]};
                txd   <= sh_q[1];
                bit_q <= bit_q - 4'd1;
                div_q <= 16'(DIV - 1);
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_first;
        st_q == ST_IDLE ##1 st_q == ST_SEND && pos_q == 9'd0;
    endsequence

    sequence s_last;
        ld && pos_q == n_q + 9'd6;
    endsequence

    stx_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_first |-> byte_d == STX_BYTE) // [R1]
        else $error("first byte is not start byte");

    etx_last_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_last |-> byte_d == ETX_BYTE ##1 st_q == ST_WAIT) // [R2]
        else $error("last byte is not end byte");

    info_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld && pos_q != 9'd0 && pos_q < n_q + 9'd6
        |-> byte_d >= INFO_BASE) // [R4]
        else $error("information byte below 128");

    ctrl_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld && (pos_q == 9'd0 || pos_q == n_q + 9'd6)
        |-> byte_d <= CTRL_MAX) // [R3]
        else $error("framing byte outside control range");

    start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld |=> !txd [*8]) // [R5]
        else $error("start bit not held low");

    stop_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(u_busy_q) |-> txd && $past(txd)) // [R5]
        else $error("line not idle after stop bit");

    len_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld && pos_q == 9'd2 |-> byte_d[6:0] == n_q[7:1]) // [R7]
        else $error("length byte does not match payload");

    type_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld && pos_q == 9'd1 |-> byte_d == (INFO_BASE | {3'h0, ptype_q}))
        else $error("type byte wrong"); // [R11]

    status_fix_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_b[7] && !status_b[5]) // [R22]
        else $error("status constant bits wrong");

    err_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_first |-> !perr_q || (ptype_q == TYPE_ERR && n_q == 9'd2))
        else $error("error packet not type 15"); // [R24]

    dlg_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_q[5] |=> dlg_q) // [R22]
        else $error("dialog request lost");
endmodule
`default_nettype wire

// file: logic/spf_pkg.sv
// constants for the scan data packet framer: apb map, framing, status
// assumes a 10 MHz apb clock and an 8n1 serial line behind the framer
//
// What this block does
// R1: every packet opens with start byte 2
// R2: end byte 3 follows the checksum
// R3: bytes 0 to 32 are framing only
// R4: all information bytes lie in 128..255
// R5: serial bytes are 8n1, one stop
// R6: type at position 1, length at 2
// R7: length byte is 128 plus payload words
// R8: payload starts at position 3
// R9: status, segment, checksum, end follow payload
// R10: distances go out in increasing sector order
// R11: type byte is 128 plus type code
// R12: type 1 carries 45 coarse bytes
// R13: type 2 sends high byte then low
// R14: receiver strips top bits, builds 14-bit word
// R15: type 2 step is 4 mm
// R16: types 11 to 14 carry 254 bytes
// R17: type 15 reports status after error
// R18: status bit 0 is person field state
// R19: status bit 1 is object field state
// R20: bit 2 device error, bit 3 warning
// R21: bit 4 active, bit 5 reserved zero
// R22: bit 6 dialog request, bit 7 one
// R23: framing never stalls measurement logic
// R24: on error send status and code
// R25: checksum by replaceable function, top bit set
// R26: segment byte is 128 plus segment index
package spf_pkg;
    // ==========================================================
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00; // type code, segment
    localparam logic [7:0] OFS_CMD   = 8'h04; // start, clear dialog
    localparam logic [7:0] OFS_PTR   = 8'h08; // payload write pointer
    localparam logic [7:0] OFS_PDATA = 8'h0C; // one payload byte
    localparam logic [7:0] OFS_PDIST = 8'h10; // one 14-bit distance
    localparam logic [7:0] OFS_ERR   = 8'h14; // error code
    localparam logic [7:0] OFS_STAT  = 8'h18; // busy and status byte
    // ==========================================================
    // field positions
    localparam int CMD_START   = 0;
    localparam int CMD_CLRDLG  = 1;
    localparam int CMD_ERRMODE = 2; // allow auto error packets
    localparam int CTRL_SEG_LO = 8;
    localparam int STAT_BUSY   = 8;
    // ==========================================================
    // framing bytes and codes
    localparam logic [7:0] STX_BYTE  = 8'h02;
    localparam logic [7:0] ETX_BYTE  = 8'h03;
    localparam logic [7:0] INFO_BASE = 8'h80;
    localparam logic [7:0] CTRL_MAX  = 8'h20;
    localparam logic [4:0] TYPE_ERR  = 5'h0F;
    localparam logic [4:0] TYPE_RST  = 5'h01;
    // ==========================================================
    // status byte bit positions
    localparam int SB_PERSON = 0;
    localparam int SB_OBJECT = 1;
    localparam int SB_ERROR  = 2;
    localparam int SB_WARN   = 3;
    localparam int SB_ACTIVE = 4;
    localparam int SB_DIALOG = 6;
    // ==========================================================
    // timing
    localparam int CLK_HZ   = 10_000_000;
    localparam int BAUD_DEF = 9600;
    // checksum step, swap here for another algorithm
    function automatic logic [6:0] csum_step(input logic [6:0] acc,
                                             input logic [7:0] b);
        csum_step = acc ^ b[6:0];
    endfunction
endpackage

// file: sim/spf_host_rx.sv
// host side serial receiver model, rebuilds 8n1 bytes from txd
// assumes DIV pclk cycles a bit and a line that idles high
`timescale 1ns/1ps
`default_nettype none
module spf_host_rx
#(
    parameter int DIV = 10
)
(
    input  wire logic       pclk,
    input  wire logic       txd,
    output logic      [7:0] rx_byte,
    output logic            rx_stb,
    output logic            rx_ferr
);
    // ==========================================================
    // bit sampler, middle of each cell so edges never matter
    initial
    begin
        rx_byte = 8'h00;
        rx_stb  = 1'b0;
        rx_ferr = 1'b0;
        forever
        begin
            @(negedge txd);
            repeat (DIV / 2) @(posedge pclk);
            if (txd !== 1'b0)
                rx_ferr = 1'b1; // glitch, not a start bit
            for (int b = 0; b < 8; b++)
            begin
                repeat (DIV) @(posedge pclk);
                rx_byte[b] = txd; // eight data bits, no parity
            end
            repeat (DIV) @(posedge pclk);
            if (txd !== 1'b1)
                rx_ferr = 1'b1; // one stop bit
            rx_stb = 1'b1; // byte kept whole, control or info
            @(posedge pclk);
            rx_stb = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: sim/spf_framer_tb.sv
// self-checking bench for the packet framer: apb driver and scenarios
// assumes spf_host_rx decodes txd; status pins stay steady in a frame
`timescale 1ns/1ps
`default_nettype none
module spf_framer_tb;
    import spf_pkg::*;
    // ==========================================================
    // signals
    localparam int BAUD = 1_000_000; // ten clocks a bit, short runs
    localparam int DIV  = CLK_HZ / BAUD;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, berr, txd, frame_busy;
    logic        person_field_switch_state, object_field_switch_state;
    logic        dev_error, window_warn, func_active, dialog_req;
    logic        dlg_exp; // sticky dialog flag as expected
    logic [7:0]  rx_byte;
    logic        rx_stb, rx_ferr;
    logic [7:0]  rx_q[$]; // bytes seen by the host model
    logic [7:0]  pay[$];  // payload that should go out
    int          fails, checks_done;
    // ==========================================================
    // device and host
    spf_framer #(.BAUD(BAUD)) u_spf_framer
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .person_field_switch_state,
        .object_field_switch_state, .dev_error, .window_warn,
        .func_active, .dialog_req, .txd, .frame_busy
    );
    spf_host_rx #(.DIV(DIV)) u_spf_host_rx
    (
        .pclk, .txd, .rx_byte, .rx_stb, .rx_ferr
    );
    always @(posedge rx_stb) rx_q.push_back(rx_byte);
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ==========================================================
    // helpers
    task automatic check(input string w, input logic [31:0] e,
                         input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    // one transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check("apb answer", 32'h1, {31'h0, pready});
        rd      = prdata;
        berr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [7:0] st_exp();
        return {1'b1, dlg_exp, 1'b0, func_active, window_warn, dev_error,
                object_field_switch_state, person_field_switch_state};
    endfunction
    // start twice (second refused while busy), then judge every byte
    task automatic run_frame(input logic [4:0] code,
                             input logic [1:0] seg,
                             input logic [31:0] cmd);
        logic [7:0] ex[$];
        logic [6:0] cs;
        int         n, i;
        n  = 0;
        i  = pay.size();
        cs = 7'h00;
        ex = {8'h80 | 8'(code), 8'h80 | 8'(i / 2)};
        ex = {ex, pay, st_exp(), 8'h80 | 8'(seg)};
        foreach (ex[k]) cs ^= ex[k][6:0];
        rx_q.delete();
        apb(1'b1, OFS_CMD, cmd);
        apb(1'b1, OFS_CMD, cmd);
        while (frame_busy !== 1'b0 && n < 40_000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (3 * DIV) @(posedge pclk);
        check("busy after frame", 32'h0, {31'h0, frame_busy});
        check("frame bytes", 32'(i + 7), 32'(rx_q.size()));
        check("start byte", STX_BYTE, rx_q[0]);
        check("type byte", ex[0], rx_q[1]);
        check("length byte", ex[1], rx_q[2]);
        for (int k = 0; k < i; k++)
            check("payload byte", pay[k], rx_q[3 + k]);
        check("status byte", ex[2 + i], rx_q[3 + i]);
        check("segment byte", ex[3 + i], rx_q[4 + i]);
        check("checksum byte", {1'b1, cs}, rx_q[5 + i]);
        check("end byte", ETX_BYTE, rx_q[6 + i]);
    endtask
    // ==========================================================
    // scenarios
    task automatic s_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", 32'h0000_0001, rd);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped error", 32'h1, {31'h0, berr});
        check("unmapped data", 32'h0, rd);
        apb(1'b0, OFS_STAT, 32'h0);
        check("status idle", {24'h0, st_exp()}, rd);
    endtask
    // fine distances: high seven bits first, 4 mm a step
    task automatic s_fine();
        int          mm[3] = '{16380, 1364, 8188};
        logic [13:0] w;
        pay.delete();
        apb(1'b1, OFS_CTRL, 32'h0000_0302);
        apb(1'b1, OFS_PTR, 32'h0);
        foreach (mm[k])
        begin
            w = 14'(mm[k] / 4);
            apb(1'b1, OFS_PDIST, {18'h0, w});
            pay.push_back({1'b1, w[13:7]});
            pay.push_back({1'b1, w[6:0]});
        end
        run_frame(5'h02, 2'h3, 32'h1);
        foreach (mm[k])
        begin
            w = {rx_q[3 + 2 * k][6:0], rx_q[4 + 2 * k][6:0]};
            w[13:12] = 2'b00; // receiver clears the two upper bits
            check("decoded mm", 32'(mm[k]), {16'h0, w, 2'b00});
        end
    endtask
    // coarse distances, odd count, dialog flag sticky then cleared
    task automatic s_coarse();
        pay.delete();
        object_field_switch_state <= 1'b1;
        dialog_req                <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        dialog_req <= 1'b0;
        dlg_exp = 1'b1;
        apb(1'b1, OFS_PTR, 32'h0);
        for (int k = 0; k < 45; k++)
        begin
            apb(1'b1, OFS_PDATA, 32'(k + 7));
            pay.push_back(8'h80 | 8'(k + 7));
        end
        run_frame(5'h01, 2'h0, 32'h1);
        apb(1'b1, OFS_CMD, 32'h2);
        dlg_exp = 1'b0;
        apb(1'b0, OFS_STAT, 32'h0);
        check("dialog cleared", {24'h0, st_exp()}, rd);
    endtask
    // a full parameter block, then every other block code
    task automatic s_params();
        pay.delete();
        apb(1'b1, OFS_CTRL, 32'h0000_010B);
        apb(1'b1, OFS_PTR, 32'h0);
        for (int k = 0; k < 254; k++)
        begin
            apb(1'b1, OFS_PDATA, 32'(k));
            pay.push_back(8'h80 | 8'(k));
        end
        run_frame(5'h0B, 2'h1, 32'h1);
        pay = {8'hA5, 8'hC3};
        for (int c = 12; c <= 15; c++)
        begin
            apb(1'b1, OFS_CTRL, 32'(c));
            apb(1'b1, OFS_PTR, 32'h0);
            apb(1'b1, OFS_PDATA, 32'h25);
            apb(1'b1, OFS_PDATA, 32'h43);
            run_frame(5'(c), 2'h0, 32'h1);
        end
    endtask
    // error mode: status and error code replace the distances
    task automatic s_error();
        dev_error <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        apb(1'b1, OFS_ERR, 32'h0000_0D2A);
        pay = {8'h9A, 8'hAA};
        // enable first: a start in the same write sees the old mode
        apb(1'b1, OFS_CMD, 32'h4);
        run_frame(TYPE_ERR, 2'h0, 32'h5);
        dev_error <= 1'b0;
    endtask
    // ==========================================================
    // verdict, main sequence and watchdog
    task automatic complete_run();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        fails       = 0;
        checks_done = 0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        person_field_switch_state = 1'b1;
        object_field_switch_state = 1'b0;
        dev_error   = 1'b0;
        window_warn = 1'b1;
        func_active = 1'b1;
        dialog_req  = 1'b0;
        dlg_exp     = 1'b0;
        presetn     = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        s_regs();
        s_fine();
        s_coarse();
        s_params();
        s_error();
        check("host framing", 32'h0, {31'h0, rx_ferr});
        complete_run();
    end
    initial
    begin
        repeat (80_000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
